// ===== rtl/ncor_pkg.sv
// package: constants, register map and carrier types for the oscillator select / overrange block
package ncor_pkg;
   localparam int unsigned SAMP_W          = 12;
   localparam int unsigned CNT_W           = 16;
   localparam int unsigned NUM_OSC         = 4;
   localparam int unsigned PHASE_W         = 32;
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_THR_FIRST   = 8'h04;
   localparam logic [7:0]  REG_THR_SECOND  = 8'h08;
   localparam logic [7:0]  REG_PULSE_LEN   = 8'h0C;
   localparam logic [7:0]  REG_STATUS      = 8'h10;
   localparam logic [7:0]  REG_IRQ_STAT    = 8'h14;
   localparam logic [7:0]  REG_IRQ_MASK    = 8'h18;
   localparam logic [7:0]  REG_PHASE_INC   = 8'h20;
   localparam int unsigned CTRL_SRC_BIT    = 0;
   localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
   localparam logic [11:0] RST_THR_FIRST   = 12'h0_700;
   localparam logic [11:0] RST_THR_SECOND  = 12'h0_7F0;
   localparam logic [15:0] RST_PULSE_LEN   = 16'h0_008;
   localparam logic [31:0] RST_PHASE_INC   = 32'h0100_0000;
   localparam logic [31:0] BAD_ADDR_DATA   = 32'hDEAD_0000;
   localparam int unsigned IRQ_W           = 6;

   typedef struct packed {
      logic over_first;
      logic over_second;
   } ncor_flags_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
   } ncor_req_t;
endpackage

// ===== rtl/ncor_osc_bank.sv
// four free-running phase accumulators with a selected-phase output register
`timescale 1ns/1ps
module ncor_osc_bank
   import ncor_pkg::*;
(
   input  wire logic               mclk_i,     // core clock
   input  wire logic               rstn_i,     // sync reset, active low
   input  wire logic               run_i,      // analog up, accumulators run
   input  wire logic [PHASE_W-1:0] inc_i,      // base phase increment
   input  wire logic [1:0]         sel_i,      // active oscillator index
   output logic      [PHASE_W-1:0] phase_o     // phase of selected oscillator
);
   logic [PHASE_W-1:0] acc [NUM_OSC];

   // each oscillator steps by a distinct multiple so they differ in frequency
   function automatic logic [PHASE_W-1:0] step(input logic [PHASE_W-1:0] b,
                                                 input int unsigned k);
      step = b * PHASE_W'(k + 1);
   endfunction

   // unselected oscillators keep advancing to stay phase coherent
   always_ff @(posedge mclk_i) begin
      for (int k = 0; k < NUM_OSC; k++) begin
         if (!rstn_i) begin
            acc[k] <= '0;
         end else if (run_i) begin
            acc[k] <= acc[k] + step(inc_i, k);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         phase_o <= '0;
      end else begin
         phase_o <= acc[sel_i];
      end
   end
endmodule

// ===== rtl/ncor_over_det.sv
// overrange detector for one channel: two thresholds, minimum pulse stretch
`timescale 1ns/1ps
module ncor_over_det
   import ncor_pkg::*;
(
   input  wire logic              mclk_i,      // core clock
   input  wire logic              rstn_i,      // sync reset, active low
   input  wire logic              en_i,        // analog powered
   input  wire logic [SAMP_W-1:0] samp_i,      // signed sample
   input  wire logic [SAMP_W-1:0] thr_first_i, // first threshold
   input  wire logic [SAMP_W-1:0] thr_second_i,// second threshold
   input  wire logic [CNT_W-1:0]  min_len_i,   // minimum pulse cycles
   output ncor_flags_t            flags_o      // registered flags
);
   logic [CNT_W-1:0] cnt_first;
   logic [CNT_W-1:0] cnt_second;
   wire  [SAMP_W-1:0] mag;
   wire  hit_first;
   wire  hit_second;

   // magnitude saturates the most negative code instead of wrapping
   function automatic logic [SAMP_W-1:0] absval(input logic [SAMP_W-1:0] s);
      logic [SAMP_W-1:0] n;
      n = SAMP_W'(~s + 1'b1);
      if (!s[SAMP_W-1])
         absval = s;
      else if (n[SAMP_W-1])
         absval = {1'b0, {(SAMP_W-1){1'b1}}};
      else
         absval = n;
   endfunction

   assign mag        = absval(samp_i);
   assign hit_first  = en_i && (mag > thr_first_i);
   assign hit_second = en_i && (mag > thr_second_i);

   // counter reloads on every hit; flag drops once below and expired
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         cnt_first  <= '0;
         cnt_second <= '0;
         flags_o    <= '0;
      end else begin
         if (hit_first) begin
            cnt_first           <= min_len_i;
            flags_o.over_first  <= 1'b1;
         end else if (cnt_first > 16'h0_001) begin
            cnt_first <= cnt_first - 1'b1;
         end else begin
            cnt_first           <= '0;
            flags_o.over_first  <= 1'b0;
         end
         if (hit_second) begin
            cnt_second          <= min_len_i;
            flags_o.over_second <= 1'b1;
         end else if (cnt_second > 16'h0_001) begin
            cnt_second <= cnt_second - 1'b1;
         end else begin
            cnt_second          <= '0;
            flags_o.over_second <= 1'b0;
         end
      end
   end
endmodule

// ===== rtl/ncor_top.sv
// oscillator select pins, overrange flags and shutdown pin, with Avalon-MM regs
`timescale 1ns/1ps
module ncor_top
   import ncor_pkg::*;
(
   input  wire logic               mclk_i,                  // 250 MHz clock
   input  wire logic               rstn_i,                  // sync reset, low
   input  wire logic               ddc_a_osc_sel_lsb_i,     // async pin
   input  wire logic               ddc_a_osc_sel_msb_i,     // async pin
   input  wire logic               ddc_b_osc_sel_lsb_i,     // async pin
   input  wire logic               ddc_b_osc_sel_msb_i,     // async pin
   input  wire logic               analog_shutdown_pin_i,   // async pin, high
   input  wire logic [SAMP_W-1:0]  samp_a_i,                // channel a sample
   input  wire logic [SAMP_W-1:0]  samp_b_i,                // channel b sample
   input  wire logic [7:0]         avs_address_i,           // byte address
   input  wire logic               avs_read_i,              // read request
   input  wire logic               avs_write_i,             // write request
   input  wire logic [31:0]        avs_writedata_i,         // write data
   input  wire logic [3:0]         avs_byteenable_i,        // byte enables
   output logic      [31:0]        avs_readdata_o,          // read data
   output logic                    avs_waitrequest_o,       // stall
   output logic                    chan_a_over_flag_first_o,  // flag
   output logic                    chan_a_over_flag_second_o, // flag
   output logic                    chan_b_over_flag_first_o,  // flag
   output logic                    chan_b_over_flag_second_o, // flag
   output logic                    serializer_en_o,         // lanes enabled
   output logic                    analog_en_o,             // analog enabled
   output logic      [PHASE_W-1:0] ddc_a_phase_o,           // mixer phase a
   output logic      [PHASE_W-1:0] ddc_b_phase_o,           // mixer phase b
   output logic                    irq_o                    // level interrupt
);
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACK  = 3'b010,
      BUS_DONE = 3'b100
   } ncor_bus_t;

   // synchroniser stages: meta stage read only by the second stage
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic [1:0] sel_a;
   logic [1:0] sel_b;
   logic [31:0] ctrl;
   logic [SAMP_W-1:0] overrange_threshold_first;
   logic [SAMP_W-1:0] overrange_threshold_second;
   logic [CNT_W-1:0]  overrange_min_pulse_len;
   logic [PHASE_W-1:0] phase_inc;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] evt_prev;
   ncor_bus_t   bus_state;
   ncor_bus_t   next_bus_state;
   ncor_flags_t flags_a;
   ncor_flags_t flags_b;
   logic [PHASE_W-1:0] phase_a;
   logic [PHASE_W-1:0] phase_b;
   logic [31:0] next_readdata;

   wire       shutdown   = pin_sync[4];
   wire       osc_src    = ctrl[CTRL_SRC_BIT];
   wire [1:0] pin_sel_a  = pin_sync[1:0];
   wire [1:0] pin_sel_b  = pin_sync[3:2];
   wire       bus_req    = avs_read_i | avs_write_i;
   wire       wr_take    = (bus_state == BUS_ACK) && avs_write_i;
   wire [IRQ_W-1:0] evt_now = {shutdown, ~shutdown,
                               flags_b.over_second, flags_b.over_first,
                               flags_a.over_second, flags_a.over_first};
   wire [IRQ_W-1:0] evt_rise = evt_now & ~evt_prev;
   wire [IRQ_W-1:0] irq_clr  = (wr_take && avs_address_i == REG_IRQ_STAT
                                && avs_byteenable_i[0])
                               ? avs_writedata_i[IRQ_W-1:0] : '0;

   // merge written bytes into an old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      for (int i = 0; i < 4; i++)
         merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
   endfunction

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = wr_take && (avs_address_i == a);
   endfunction

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {analog_shutdown_pin_i, ddc_b_osc_sel_msb_i,
                      ddc_b_osc_sel_lsb_i, ddc_a_osc_sel_msb_i,
                      ddc_a_osc_sel_lsb_i};
         pin_sync <= pin_meta;
      end
   end

   // with source zero the index freezes; pins only steer when source is one
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sel_a <= '0;
         sel_b <= '0;
      end else if (osc_src) begin
         sel_a <= pin_sel_a;
         sel_b <= pin_sel_b;
      end
   end

   ncor_osc_bank u_osc_a (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .run_i   (~shutdown),
      .inc_i   (phase_inc),
      .sel_i   (sel_a),
      .phase_o (phase_a)
   );

   ncor_osc_bank u_osc_b (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .run_i   (~shutdown),
      .inc_i   (phase_inc),
      .sel_i   (sel_b),
      .phase_o (phase_b)
   );

   // one detector per channel, each fed only its own samples
   ncor_over_det u_det_a (
      .mclk_i       (mclk_i),
      .rstn_i       (rstn_i),
      .en_i         (~shutdown),
      .samp_i       (samp_a_i),
      .thr_first_i  (overrange_threshold_first),
      .thr_second_i (overrange_threshold_second),
      .min_len_i    (overrange_min_pulse_len),
      .flags_o      (flags_a)
   );

   ncor_over_det u_det_b (
      .mclk_i       (mclk_i),
      .rstn_i       (rstn_i),
      .en_i         (~shutdown),
      .samp_i       (samp_b_i),
      .thr_first_i  (overrange_threshold_first),
      .thr_second_i (overrange_threshold_second),
      .min_len_i    (overrange_min_pulse_len),
      .flags_o      (flags_b)
   );

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         chan_a_over_flag_first_o  <= 1'b0;
         chan_a_over_flag_second_o <= 1'b0;
         chan_b_over_flag_first_o  <= 1'b0;
         chan_b_over_flag_second_o <= 1'b0;
         analog_en_o               <= 1'b0;
         serializer_en_o           <= 1'b0;
         ddc_a_phase_o             <= '0;
         ddc_b_phase_o             <= '0;
      end else begin
         chan_a_over_flag_first_o  <= flags_a.over_first;
         chan_a_over_flag_second_o <= flags_a.over_second;
         chan_b_over_flag_first_o  <= flags_b.over_first;
         chan_b_over_flag_second_o <= flags_b.over_second;
         analog_en_o               <= ~shutdown;
         serializer_en_o           <= ~shutdown;
         ddc_a_phase_o             <= phase_a;
         ddc_b_phase_o             <= phase_b;
      end
   end

   // bus: one wait cycle then ack, so an access starting in BUS_IDLE takes two edges
   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         BUS_IDLE: next_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
         BUS_ACK:  next_bus_state = BUS_DONE;
         BUS_DONE: next_bus_state = BUS_IDLE;
         default:  next_bus_state = BUS_IDLE;
      endcase
   end

   always_comb begin
      case (avs_address_i)
         REG_CTRL:       next_readdata = ctrl;
         REG_THR_FIRST:  next_readdata = {20'h0_0000,
                                          overrange_threshold_first};
         REG_THR_SECOND: next_readdata = {20'h0_0000,
                                          overrange_threshold_second};
         REG_PULSE_LEN:  next_readdata = {16'h0_000,
                                          overrange_min_pulse_len};
         REG_STATUS:     next_readdata = {23'h00_0000, shutdown,
                                          sel_b, sel_a,
                                          flags_b.over_second,
                                          flags_b.over_first,
                                          flags_a.over_second,
                                          flags_a.over_first};
         REG_IRQ_STAT:   next_readdata = {26'h000_0000, irq_stat};
         REG_IRQ_MASK:   next_readdata = {26'h000_0000, irq_mask};
         REG_PHASE_INC:  next_readdata = phase_inc;
         default:        next_readdata = BAD_ADDR_DATA;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         bus_state         <= BUS_IDLE;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= '0;
      end else begin
         bus_state         <= next_bus_state;
         avs_waitrequest_o <= ~(next_bus_state == BUS_ACK);
         if (next_bus_state == BUS_ACK)
            avs_readdata_o <= next_readdata;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ctrl                       <= RST_CTRL;
         overrange_threshold_first  <= RST_THR_FIRST;
         overrange_threshold_second <= RST_THR_SECOND;
         overrange_min_pulse_len    <= RST_PULSE_LEN;
         phase_inc                  <= RST_PHASE_INC;
         irq_mask                   <= '0;
      end else begin
         if (wr_hit(REG_CTRL))
            ctrl <= merge(ctrl, avs_writedata_i, avs_byteenable_i)
                    & 32'h0000_0001;
         if (wr_hit(REG_THR_FIRST))
            overrange_threshold_first <= SAMP_W'(merge(
               {20'h0_0000, overrange_threshold_first},
               avs_writedata_i, avs_byteenable_i));
         if (wr_hit(REG_THR_SECOND))
            overrange_threshold_second <= SAMP_W'(merge(
               {20'h0_0000, overrange_threshold_second},
               avs_writedata_i, avs_byteenable_i));
         if (wr_hit(REG_PULSE_LEN))
            overrange_min_pulse_len <= CNT_W'(merge(
               {16'h0_000, overrange_min_pulse_len},
               avs_writedata_i, avs_byteenable_i));
         if (wr_hit(REG_PHASE_INC))
            phase_inc <= merge(phase_inc, avs_writedata_i, avs_byteenable_i);
         if (wr_hit(REG_IRQ_MASK) && avs_byteenable_i[0])
            irq_mask <= avs_writedata_i[IRQ_W-1:0];
      end
   end

   // a rising event in the clearing cycle still sets its bit
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         irq_stat <= '0;
         // idle pins: shutdown low, so the analog-up term starts high
         evt_prev <= 6'h10;
         irq_o    <= 1'b0;
      end else begin
         evt_prev <= evt_now;
         irq_stat <= (irq_stat & ~irq_clr) | evt_rise;
         irq_o    <= |(((irq_stat & ~irq_clr) | evt_rise) & irq_mask);
      end
   end

   a_sel_gated: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !osc_src |=> $stable(sel_a) && $stable(sel_b))
      else $error("select index changed while source is zero");
   a_sel_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      osc_src |=> sel_a == $past(pin_sel_a))
      else $error("select index does not follow pins");
   a_sync_depth: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      ##2 pin_sync[0] == $past(ddc_a_osc_sel_lsb_i, 2))
      else $error("select pin not delayed by two stages");
   a_over_first: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      u_det_a.hit_first |=> flags_a.over_first ##1
      chan_a_over_flag_first_o)
      else $error("channel a first flag missed a hit");
   a_over_second: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      u_det_b.hit_second |=> flags_b.over_second)
      else $error("channel b second flag missed a hit");
   a_pulse_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(flags_a.over_first) && overrange_min_pulse_len >= 16'h0_003
      |-> flags_a.over_first[*3])
      else $error("overrange pulse shorter than minimum");
   a_pulse_drop: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !u_det_a.hit_first && u_det_a.cnt_first <= 16'h0_001
      |=> !flags_a.over_first)
      else $error("overrange flag stuck after expiry");
   a_shutdown: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      shutdown |=> !analog_en_o && !serializer_en_o && !flags_b.over_first)
      else $error("analog or lanes active in shutdown");
   a_chan_split: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !shutdown && !samp_b_i[SAMP_W-1] && samp_b_i > overrange_threshold_first
      |=> flags_b.over_first)
      else $error("channel b flag not from own sample");
   a_bus_wait: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(bus_req) && bus_state == BUS_IDLE |=> !avs_waitrequest_o)
      else $error("bus answer not after one cycle");

   c_sel_switch: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      osc_src && $changed(sel_a));
   c_flag_pulse: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      $fell(chan_b_over_flag_second_o));
   c_irq: cover property (@(posedge mclk_i) disable iff (!rstn_i) $rose(irq_o));
   c_shutdown: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(shutdown));
endmodule

// ===== testbench/ncor_ctrl_model.sv
// controller model: drives the oscillator select and shutdown pins
`timescale 1ns/1ps
module ncor_ctrl_model (
   input  wire logic       mclk_i,      // core clock
   output logic      [1:0] sel_a_o,     // ddc a select pins, msb:lsb
   output logic      [1:0] sel_b_o,     // ddc b select pins, msb:lsb
   output logic            shutdown_o   // analog shutdown pin
);
   initial begin
      sel_a_o = 2'h0;
      sel_b_o = 2'h0;
      shutdown_o = 1'b0;
   end

   // pins move with no regard to the bus; the device must resynchronise
   task automatic pick(input logic [1:0] a, input logic [1:0] b);
      @(posedge mclk_i);
      sel_a_o <= a;
      sel_b_o <= b;
   endtask

   // only used for a calibration window, never to save power
   task automatic calib(input logic on);
      @(posedge mclk_i);
      shutdown_o <= on;
   endtask
endmodule

// ===== testbench/tb_nco_select_overrange_pins.sv
// self-checking bench for the oscillator select and overrange block
`timescale 1ns/1ps
module tb_nco_select_overrange_pins;
   import ncor_pkg::*;
   logic mclk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [7:0]  avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
   logic [11:0] samp_a_i = 12'h000, samp_b_i = 12'h000;
   logic [1:0]  sel_a, sel_b;
   logic shut, avs_waitrequest_o, serializer_en_o, analog_en_o, irq_o;
   logic a0, a1, b0, b1;
   logic [31:0] ddc_a_phase_o, ddc_b_phase_o;
   logic [31:0] exp_q[$];
   int compares = 0, miscompares = 0;
   localparam int L = 5;

   ncor_ctrl_model ctrl_u (.mclk_i(mclk_i), .sel_a_o(sel_a), .sel_b_o(sel_b),
      .shutdown_o(shut));
   ncor_top dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .ddc_a_osc_sel_lsb_i(sel_a[0]), .ddc_a_osc_sel_msb_i(sel_a[1]),
      .ddc_b_osc_sel_lsb_i(sel_b[0]), .ddc_b_osc_sel_msb_i(sel_b[1]),
      .analog_shutdown_pin_i(shut), .samp_a_i(samp_a_i), .samp_b_i(samp_b_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .chan_a_over_flag_first_o(a0), .chan_a_over_flag_second_o(a1),
      .chan_b_over_flag_first_o(b0), .chan_b_over_flag_second_o(b1),
      .serializer_en_o(serializer_en_o), .analog_en_o(analog_en_o),
      .ddc_a_phase_o(ddc_a_phase_o), .ddc_b_phase_o(ddc_b_phase_o),
      .irq_o(irq_o));

   initial begin
      forever #2 mclk_i = ~mclk_i;
   end

   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // the request is held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   // read results are matched against the oldest note as they appear
   always @(posedge mclk_i) begin
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
         if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
         else check("readdata", exp_q.pop_front(), avs_readdata_o);
      end
   end

   // quiet samples stay strictly below the lowest programmed threshold
   function automatic logic [11:0] quiet();
      logic [11:0] v;
      v = 12'($urandom_range(0, 255));
      return ($urandom_range(0, 1) != 0) ? -v : v;
   endfunction

   task automatic pulse(input logic [11:0] sa, input logic [11:0] sb,
                        input logic [3:0] hit);
      // counts are four-state so an unknown flag spoils the total
      logic [31:0] cnt[4] = '{0, 0, 0, 0};
      @(posedge mclk_i);
      samp_a_i <= sa;
      samp_b_i <= sb;
      for (int c = 0; c < 20; c++) begin
         @(posedge mclk_i);
         cnt[0] += 32'(a0);
         cnt[1] += 32'(a1);
         cnt[2] += 32'(b0);
         cnt[3] += 32'(b1);
         samp_a_i <= quiet();
         samp_b_i <= quiet();
      end
      for (int i = 0; i < 4; i++) begin
         check("flag cycles", hit[i] ? L : 0, cnt[i]);
      end
   endtask

   initial begin
      logic [7:0]  ra[6] = '{REG_CTRL, REG_THR_FIRST, REG_THR_SECOND,
                             REG_PULSE_LEN, REG_PHASE_INC, 8'h40};
      logic [31:0] rv[6] = '{RST_CTRL, 32'(RST_THR_FIRST),
                             32'(RST_THR_SECOND), 32'(RST_PULSE_LEN),
                             RST_PHASE_INC, BAD_ADDR_DATA};
      logic [31:0] p, r;
      void'($urandom(58));
      repeat (8) @(posedge mclk_i);
      rstn_i <= 1'b1;
      bus(1'b1, 8'h40, 32'h1234_5678);
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
      r = 32'($urandom_range(0, 4095));
      bus(1'b1, REG_THR_FIRST, r);
      rd(REG_THR_FIRST, r);
      $display("test registers done");
      ctrl_u.pick(2'h3, 2'h0);
      repeat (6) @(posedge mclk_i);
      rd(REG_STATUS, 32'h0000_0000);
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         ctrl_u.pick(2'(k), 2'h0);
         repeat (8) @(posedge mclk_i);
         p = ddc_a_phase_o;
         check("coherent phase", 32'((k + 1) * ddc_b_phase_o), p);
         @(posedge mclk_i);
         check("phase step", 32'((k + 1) * RST_PHASE_INC),
               ddc_a_phase_o - p);
         rd(REG_STATUS, 32'(k << 4));
      end
      ctrl_u.pick(2'h1, 2'h2);
      repeat (6) @(posedge mclk_i);
      rd(REG_STATUS, 32'h0000_0090);
      $display("test select done");
      bus(1'b1, REG_THR_FIRST, 32'h0000_0100);
      bus(1'b1, REG_THR_SECOND, 32'h0000_0200);
      bus(1'b1, REG_PULSE_LEN, L);
      pulse(12'h100, 12'h200, 4'b0100);
      pulse(12'h180, 12'h000, 4'b0001);
      pulse(12'h000, 12'hDB0, 4'b1100);
      pulse(12'h800, 12'h000, 4'b0011);
      bus(1'b1, REG_IRQ_STAT, 32'h0000_003F);
      rd(REG_IRQ_STAT, 32'h0000_0000);
      $display("test overrange done");
      bus(1'b1, REG_IRQ_MASK, 32'h0000_0020);
      ctrl_u.calib(1'b1);
      repeat (6) @(posedge mclk_i);
      check("analog_en", 32'h0, 32'(analog_en_o));
      check("serializer_en", 32'h0, 32'(serializer_en_o));
      check("irq raised", 32'h1, 32'(irq_o));
      pulse(12'h7FF, 12'h7FF, 4'b0000);
      rd(REG_IRQ_STAT, 32'h0000_0020);
      bus(1'b1, REG_IRQ_STAT, 32'h0000_0020);
      repeat (3) @(posedge mclk_i);
      check("irq cleared", 32'h0, 32'(irq_o));
      ctrl_u.calib(1'b0);
      repeat (6) @(posedge mclk_i);
      check("analog_en", 32'h1, 32'(analog_en_o));
      check("serializer_en", 32'h1, 32'(serializer_en_o));
      check("irq masked", 32'h0, 32'(irq_o));
      rd(REG_IRQ_STAT, 32'h0000_0010);
      bus(1'b1, REG_IRQ_MASK, 32'h0000_0010);
      repeat (3) @(posedge mclk_i);
      check("irq unmasked", 32'h1, 32'(irq_o));
      bus(1'b1, REG_IRQ_STAT, 32'h0000_0010);
      repeat (3) @(posedge mclk_i);
      check("irq cleared", 32'h0, 32'(irq_o));
      $display("test shutdown done");
      close_out();
   end

   // the whole sequence needs well under 2000 cycles
   initial begin
      #40000;
      miscompares++;
      close_out();
   end
endmodule
